// ===== pa_cycle_clock.sv
// divide-by-four instruction cycle clock for the clock-out pin mode
`default_nettype none
`include "pa_gpio_params.svh"
module pa_cycle_clock (
	input  wire logic clock,
	input  wire logic rst,
	output var  logic cyc_clk
);
	typedef struct packed {
		logic [1:0] cnt;
		logic       clk;
	} st_s;
	st_s st_q;
	st_s st_d;

	always_comb begin
		st_d = st_q;
		st_d.cnt = st_q.cnt + 2'h1;
		if (st_q.cnt == `PA_CYC_DIV) begin
			st_d.clk = 1'b1;
		end else if (st_q.cnt == 2'h1) begin
			st_d.clk = 1'b0;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign cyc_clk = st_q.clk;
endmodule : pa_cycle_clock
`default_nettype wire

// ===== pa_gpio.sv
// port a general purpose i/o with interrupt-on-change, wishbone slave
// Operation
// RULE1: five positions; 5,4 bidirectional, 3,1,0 input only; others read zero
// RULE2: direction 1 turns driver off; 0 drives the latch onto the pin
// RULE3: pin register reads pin levels; writes go into the output latch
// RULE4: latch register is addressable and reads back the latch, not pins
// RULE5: per-pin change enable bits, 1 enables, reset to zero
// RULE6: global change enable gates the change interrupt
// RULE7: only pins set as inputs take part in the comparison
// RULE8: enabled inputs compared with last-read snapshot; mismatches ored into flag
// RULE9: change event produces a wake request from sleep and idle
// RULE10: pin register access refreshes snapshot, except file-to-file moves
// RULE11: flag keeps setting while mismatch persists; clear does not stick
// RULE12: snapshot survives master-clear and brown-out resets
// RULE13: usb operation disables change detection on positions 0 and 1
// RULE14: positions 1,0 digital input only with enables 11 and usb off
// RULE15: pull-up on only when its enable is 1 and global disable 0
// RULE16: pull-up forced off for outputs; all off after power-on reset
// RULE17: position 4 analog when channel 3 selected; reads zero; set at power-on
// RULE18: positions 0,1 have no direction bits; usb module sets their direction
// RULE19: position 3 is digital input only when master clear pin disabled
// RULE20: with master clear enabled bit 3 reads zero; always read only
// RULE21: oscillator use of positions 4,5 makes their bits read zero; int clock-out mode leaves both readable
// RULE22: crystal modes force direction bits 5,4 to read one
// RULE23: position 4 drives its latch only in the three with-io modes
// RULE24: rc, int clock-out and ec modes put cycle clock on position 4
// RULE25: change request raised when flag and global enable are both set
`default_nettype none
`include "pa_gpio_params.svh"
module pa_gpio (
	input  wire logic                  clock,
	input  wire logic                  rst,
	input  wire logic                  por,
	input  wire logic                  wb_cyc_i,
	input  wire logic                  wb_stb_i,
	input  wire logic                  wb_we_i,
	input  wire logic [3:0]            wb_adr_i,
	input  wire logic [7:0]            wb_dat_i,
	input  wire logic                  wb_sel_i,
	output var  logic [7:0]            wb_dat_o,
	output var  logic                  wb_ack_o,
	input  wire logic                  file_to_file_move,
	input  wire logic [7:0]            pin_in,
	output var  logic [7:0]            pin_out,
	output var  logic [7:0]            pin_oe,
	output var  logic [7:0]            pin_pullup,
	output var  logic                  change_irq,
	output var  logic                  change_irq_priority,
	output var  logic                  change_wake,
	output var  logic                  usb_module_enable
);
	typedef struct packed {
		logic [7:0] dir;
		logic [7:0] lat;
		logic [7:0] wpu;
		logic [7:0] ioc;
		logic [7:0] analog_select;
		logic [7:0] usbcon;
		logic [7:0] irqcon;
		logic [7:0] irqcon2;
		logic [3:0] osc;
		logic       master_clear_pin_enable;
		logic [7:0] rdat;
		logic       ack;
		logic [7:0] out;
		logic [7:0] oe;
		logic [7:0] pu;
		logic       irq;
		logic       wake;
	} st_s;

	// snapshot held apart: power-on clears it, master-clear and brown-out do not
	logic [7:0] snap_q;
	logic [7:0] snap_d;
	st_s        st_q;
	st_s        st_d;
	logic [7:0] pin_sync;
	logic       cyc_clk;

	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_sync
			pa_sync3 u_sync (
				.clock     (clock),
				.rst       (rst),
				.pin_in    (pin_in[g]),
				.level_out (pin_sync[g])
			);
		end
	endgenerate

	pa_cycle_clock u_cyc (
		.clock   (clock),
		.rst     (rst),
		.cyc_clk (cyc_clk)
	);

	pa_gpio_pkg::osc_mode_e osc_mode;
	logic       osc_pins;
	logic       xtal_mode;
	logic       io4_mode;
	logic       cycle_clock_output_mode;
	logic       usb_on;
	logic [7:0] avail;
	logic [7:0] pin_view;
	logic [7:0] dir_eff;
	logic [7:0] cmp_en;
	logic       mismatch;
	logic       access;
	logic       wr;
	logic       pin_acc;

	always_comb begin
		osc_mode    = pa_gpio_pkg::osc_mode_e'(st_q.osc);
		xtal_mode   = (osc_mode == pa_gpio_pkg::osc_lp) || (osc_mode == pa_gpio_pkg::osc_xt)
			|| (osc_mode == pa_gpio_pkg::osc_hs);
		io4_mode    = (osc_mode == pa_gpio_pkg::osc_rc_osc_with_io_mode) || (osc_mode == pa_gpio_pkg::osc_int2)
			|| (osc_mode == pa_gpio_pkg::osc_ext_clock_with_io_mode); // RULE23
		cycle_clock_output_mode = (osc_mode == pa_gpio_pkg::osc_rc) || (osc_mode == pa_gpio_pkg::osc_int1)
			|| (osc_mode == pa_gpio_pkg::osc_ec); // RULE24
		osc_pins    = !io4_mode && (osc_mode != pa_gpio_pkg::osc_int2);
		osc_pins    = !(io4_mode || osc_mode == pa_gpio_pkg::osc_int1); // RULE21
		usb_on      = st_q.usbcon[`PA_BIT_USB_MODULE_ENABLE];
		avail       = `PA_PIN_MASK; // RULE1
		if (osc_pins) begin
			avail = avail & ~`PA_BIDIR_MASK; // RULE21
		end
		if (st_q.analog_select[`PA_BIT_ANALOG_SELECT_CH3]) begin
			avail[4] = 1'b0; // RULE17
		end
		if (st_q.master_clear_pin_enable) begin
			avail[3] = 1'b0; // RULE19 RULE20
		end
		if (usb_on || (st_q.ioc[1:0] != 2'h3)) begin
			avail[1:0] = 2'h0; // RULE14 RULE18
		end
		pin_view = pin_sync & avail; // RULE3
		// positions 0,1,3 never drive; missing direction bits count as input
		dir_eff  = st_q.dir | ~`PA_BIDIR_MASK; // RULE18
		if (xtal_mode) begin
			dir_eff = dir_eff | `PA_BIDIR_MASK; // RULE22
		end
		cmp_en   = st_q.ioc & dir_eff & avail; // RULE7
		if (usb_on) begin
			cmp_en = cmp_en & ~`PA_USB_PIN_MASK; // RULE13
		end
		mismatch = |((pin_view ^ snap_q) & cmp_en); // RULE8
	end

	assign access  = wb_cyc_i && wb_stb_i && !st_q.ack;
	assign wr      = access && wb_we_i && wb_sel_i;
	assign pin_acc = access && (wb_adr_i == `PA_ADDR_PIN) && !file_to_file_move; // RULE10

	always_comb begin
		snap_d = snap_q;
		if (pin_acc) begin
			snap_d = pin_view; // RULE10
		end
	end

	always_comb begin
		st_d      = st_q;
		st_d.ack  = access;
		st_d.rdat = `PA_ZERO8;
		if (access && !wb_we_i) begin
			case (wb_adr_i)
				`PA_ADDR_PIN:     st_d.rdat = pin_view; // RULE3
				`PA_ADDR_DIR: begin
					st_d.rdat = st_q.dir & `PA_BIDIR_MASK;
					if (xtal_mode) begin
						st_d.rdat = `PA_BIDIR_MASK; // RULE22
					end else if (osc_pins) begin
						st_d.rdat = `PA_ZERO8; // RULE21
					end
				end
				`PA_ADDR_LAT:     st_d.rdat = osc_pins ? `PA_ZERO8 : st_q.lat; // RULE4 RULE21
				`PA_ADDR_WPU:     st_d.rdat = st_q.wpu;
				`PA_ADDR_IOC:     st_d.rdat = st_q.ioc;
				`PA_ADDR_ANALOG_SELECT:   st_d.rdat = st_q.analog_select;
				`PA_ADDR_USBCON:  st_d.rdat = st_q.usbcon;
				`PA_ADDR_IRQCON:  st_d.rdat = st_q.irqcon;
				`PA_ADDR_IRQCON2: st_d.rdat = st_q.irqcon2;
				`PA_ADDR_CFG:     st_d.rdat = {3'h0, st_q.master_clear_pin_enable, st_q.osc};
				default:          st_d.rdat = `PA_ZERO8;
			endcase
		end
		if (wr) begin
			case (wb_adr_i)
				`PA_ADDR_PIN:     st_d.lat = wb_dat_i & `PA_BIDIR_MASK; // RULE3
				`PA_ADDR_DIR:     st_d.dir = wb_dat_i & `PA_BIDIR_MASK;
				`PA_ADDR_LAT:     st_d.lat = wb_dat_i & `PA_BIDIR_MASK; // RULE4
				`PA_ADDR_WPU:     st_d.wpu = wb_dat_i & `PA_WPU_MASK;
				`PA_ADDR_IOC:     st_d.ioc = wb_dat_i & `PA_PIN_MASK; // RULE5
				`PA_ADDR_ANALOG_SELECT:   st_d.analog_select = wb_dat_i & `PA_ANALOG_SELECT_MASK;
				`PA_ADDR_USBCON:  st_d.usbcon = wb_dat_i & 8'h7e;
				`PA_ADDR_IRQCON:  st_d.irqcon = wb_dat_i;
				`PA_ADDR_IRQCON2: st_d.irqcon2 = wb_dat_i & 8'hf5;
				`PA_ADDR_CFG: begin
					st_d.osc   = wb_dat_i[3:0];
					st_d.master_clear_pin_enable = wb_dat_i[4];
				end
				default: begin
				end
			endcase
		end
		// hardware set beats software clear of the flag
		if (mismatch) begin
			st_d.irqcon[`PA_BIT_CHG_IF] = 1'b1; // RULE11 RULE12
		end
		st_d.oe  = `PA_ZERO8;
		st_d.out = `PA_ZERO8;
		if (!st_q.dir[5] && !xtal_mode && !osc_pins) begin
			st_d.oe[5]  = 1'b1; // RULE2
			st_d.out[5] = st_q.lat[5];
		end
		if (cycle_clock_output_mode) begin
			st_d.oe[4]  = 1'b1; // RULE24
			st_d.out[4] = cyc_clk;
		end else if (io4_mode && !st_q.dir[4]) begin
			st_d.oe[4]  = 1'b1; // RULE2 RULE23
			st_d.out[4] = st_q.lat[4];
		end
		st_d.pu = st_q.wpu & dir_eff & {8{~st_q.irqcon2[`PA_BIT_PU_DIS]}}; // RULE15 RULE16
		st_d.irq  = st_q.irqcon[`PA_BIT_CHG_IF] && st_q.irqcon[`PA_BIT_CHG_IE]; // RULE25 RULE6
		st_d.wake = st_d.irq; // RULE9
	end

	always_ff @(posedge clock or posedge por) begin
		if (por) begin
			snap_q <= `PA_ZERO8; // RULE12
		end else begin
			snap_q <= snap_d;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			st_q         <= '0;
			st_q.dir     <= `PA_DIR_RESET;
			st_q.analog_select   <= `PA_ANALOG_SELECT_RESET; // RULE17
			st_q.irqcon2 <= 8'h80; // RULE16
		end else begin
			st_q <= st_d;
		end
	end

	assign wb_dat_o            = st_q.rdat;
	assign wb_ack_o            = st_q.ack;
	assign pin_out             = st_q.out;
	assign pin_oe              = st_q.oe;
	assign pin_pullup          = st_q.pu;
	assign change_irq          = st_q.irq;
	assign change_irq_priority = st_q.irqcon2[`PA_BIT_CHG_IP];
	assign change_wake         = st_q.wake;
	assign usb_module_enable   = st_q.usbcon[`PA_BIT_USB_MODULE_ENABLE];

	a_flag_sticks: assert property (@(posedge clock) disable iff (rst)
		mismatch |=> st_q.irqcon[`PA_BIT_CHG_IF]) // RULE11
		else $error("change flag not set on mismatch");
	a_irq_gate: assert property (@(posedge clock) disable iff (rst)
		!st_q.irqcon[`PA_BIT_CHG_IE] |=> !change_irq) // RULE6
		else $error("change irq without enable");
	a_out_no_drive: assert property (@(posedge clock) disable iff (rst)
		st_q.dir[5] |=> !pin_oe[5]) // RULE2
		else $error("pin 5 driven while input");
	a_pullup_off: assert property (@(posedge clock) disable iff (rst)
		st_q.irqcon2[`PA_BIT_PU_DIS] |=> pin_pullup == `PA_ZERO8) // RULE15
		else $error("pull-up on while globally disabled");
	a_input_only: assert property (@(posedge clock) disable iff (rst)
		pin_oe[3:0] == 4'h0) // RULE1
		else $error("input-only pin driven");
	a_snap_load: assert property (@(posedge clock) disable iff (rst)
		pin_acc |=> snap_q == $past(pin_view)) // RULE10
		else $error("snapshot not refreshed");
	a_usb_mask: assert property (@(posedge clock) disable iff (rst)
		usb_on |-> cmp_en[1:0] == 2'h0) // RULE13
		else $error("usb pins in change compare");
	a_pin_read: assert property (@(posedge clock) disable iff (rst) // RULE1
		access && !wb_we_i && wb_adr_i == `PA_ADDR_PIN |=> wb_dat_o[7:6] == 2'h0 && !wb_dat_o[2])
		else $error("unimplemented pin bits read non-zero");
	a_ack_pulse: assert property (@(posedge clock) disable iff (rst)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	a_ack_follows: assert property (@(posedge clock) disable iff (rst)
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not acknowledged");
	a_latch_write: assert property (@(posedge clock) disable iff (rst) // RULE3
		wr && wb_adr_i == `PA_ADDR_PIN |=> st_q.lat == ($past(wb_dat_i) & `PA_BIDIR_MASK))
		else $error("pin register write missed the latch");
	a_latch_read: assert property (@(posedge clock) disable iff (rst) // RULE4
		access && !wb_we_i && wb_adr_i == `PA_ADDR_LAT && !osc_pins |=> wb_dat_o == $past(st_q.lat))
		else $error("latch read does not return latch");
	a_ioc_mask: assert property (@(posedge clock) disable iff (rst) // RULE5
		st_q.ioc[7:6] == 2'h0 && !st_q.ioc[2])
		else $error("unimplemented change enable bit set");
	a_irq_level: assert property (@(posedge clock) disable iff (rst) // RULE25
		change_irq == $past(st_q.irqcon[`PA_BIT_CHG_IF] && st_q.irqcon[`PA_BIT_CHG_IE]))
		else $error("change request does not follow flag and enable");
	a_wake_irq: assert property (@(posedge clock) disable iff (rst) // RULE9
		change_wake == change_irq)
		else $error("wake request differs from change request");
	a_pu_out5: assert property (@(posedge clock) disable iff (rst) // RULE16
		!dir_eff[5] |=> !pin_pullup[5])
		else $error("pull-up on for output pin 5");
	a_pu_out4: assert property (@(posedge clock) disable iff (rst) // RULE16
		!dir_eff[4] |=> !pin_pullup[4])
		else $error("pull-up on for output pin 4");
	a_pu_mask: assert property (@(posedge clock) disable iff (rst) // RULE15
		pin_pullup[7:6] == 2'h0 && pin_pullup[2:0] == 3'h0)
		else $error("pull-up on a position without one");
	a_oe_dir4: assert property (@(posedge clock) disable iff (rst) // RULE2
		st_q.dir[4] && !cycle_clock_output_mode |=> !pin_oe[4])
		else $error("pin 4 driven while input");
	a_cycle_clock_output_oe: assert property (@(posedge clock) disable iff (rst) // RULE24
		cycle_clock_output_mode |=> pin_oe[4])
		else $error("cycle clock not driven");
	a_cycle_clock_output_val: assert property (@(posedge clock) disable iff (rst) // RULE24
		cycle_clock_output_mode |=> pin_out[4] == $past(cyc_clk))
		else $error("pin 4 does not carry the cycle clock");
	a_out_latch: assert property (@(posedge clock) disable iff (rst) // RULE2
		!st_q.dir[5] && !xtal_mode && !osc_pins |=> pin_out[5] == $past(st_q.lat[5]))
		else $error("pin 5 does not drive its latch");
	a_xtal_dir: assert property (@(posedge clock) disable iff (rst) // RULE22
		access && !wb_we_i && wb_adr_i == `PA_ADDR_DIR && xtal_mode |=> wb_dat_o == `PA_BIDIR_MASK)
		else $error("direction bits not one in crystal mode");
	a_osc_pin_zero: assert property (@(posedge clock) disable iff (rst) // RULE21
		access && !wb_we_i && wb_adr_i == `PA_ADDR_PIN && osc_pins |=> wb_dat_o[5:4] == 2'h0)
		else $error("oscillator pins read non-zero");
	a_master_clear_input_zero: assert property (@(posedge clock) disable iff (rst) // RULE20
		access && !wb_we_i && wb_adr_i == `PA_ADDR_PIN && st_q.master_clear_pin_enable |=> !wb_dat_o[3])
		else $error("bit 3 read non-zero with master clear on");
	a_usb_pin_zero: assert property (@(posedge clock) disable iff (rst) // RULE14
		access && !wb_we_i && wb_adr_i == `PA_ADDR_PIN && usb_on |=> wb_dat_o[1:0] == 2'h0)
		else $error("usb pins read non-zero");
	a_ftf_keep: assert property (@(posedge clock) disable iff (rst) // RULE10
		access && wb_adr_i == `PA_ADDR_PIN && file_to_file_move |=> snap_q == $past(snap_q))
		else $error("file-to-file move refreshed snapshot");
	a_cmp_out: assert property (@(posedge clock) disable iff (rst) // RULE7
		!dir_eff[5] |-> !cmp_en[5])
		else $error("output pin in change compare");
endmodule : pa_gpio
`default_nettype wire

// ===== pa_gpio_params.svh
// register map, field positions and reset values of the port a block
`ifndef PA_GPIO_PARAMS_SVH
`define PA_GPIO_PARAMS_SVH
`define PA_ADDR_PIN       4'h0
`define PA_ADDR_DIR       4'h1
`define PA_ADDR_LAT       4'h2
`define PA_ADDR_WPU       4'h3
`define PA_ADDR_IOC       4'h4
`define PA_ADDR_ANALOG_SELECT     4'h5
`define PA_ADDR_USBCON    4'h6
`define PA_ADDR_IRQCON    4'h7
`define PA_ADDR_IRQCON2   4'h8
`define PA_ADDR_CFG       4'h9
`define PA_PIN_MASK       8'h3b
`define PA_BIDIR_MASK     8'h30
`define PA_WPU_MASK       8'h38
`define PA_ANALOG_SELECT_MASK     8'hf8
`define PA_USB_PIN_MASK   8'h03
`define PA_DIR_RESET      8'h30
`define PA_ANALOG_SELECT_RESET    8'hf8
`define PA_ZERO8          8'h00
`define PA_BIT_ANALOG_SELECT_CH3       3
`define PA_BIT_USB_MODULE_ENABLE      3
`define PA_BIT_CHG_IE     3
`define PA_BIT_CHG_IF     0
`define PA_BIT_PU_DIS     7
`define PA_BIT_CHG_IP     0
`define PA_CYC_DIV        2'h3
`endif

// ===== pa_gpio_pkg.sv
// types shared by the port a block
`default_nettype none
package pa_gpio_pkg;
	typedef enum logic [3:0] {
		osc_lp   = 4'h0,
		osc_xt   = 4'h1,
		osc_hs   = 4'h2,
		osc_ec   = 4'h3,
		osc_ext_clock_with_io_mode = 4'h4,
		osc_rc   = 4'h5,
		osc_rc_osc_with_io_mode = 4'h6,
		osc_int1 = 4'h7,
		osc_int2 = 4'h8
	} osc_mode_e;

	typedef struct packed {
		logic       cyc;
		logic       stb;
		logic       we;
		logic [3:0] adr;
		logic [7:0] dat;
		logic       sel;
	} wb_req_s;

	typedef struct packed {
		logic [7:0] dat;
		logic       ack;
	} wb_rsp_s;
endpackage : pa_gpio_pkg
`default_nettype wire

// ===== pa_pin_model.sv
// pads of port a as seen from the board side
`default_nettype none
module pa_pin_model (
	input  wire logic       clock,
	input  wire logic [7:0] pin_out,
	input  wire logic [7:0] pin_oe,
	input  wire logic [7:0] pin_pullup,
	input  wire logic [7:0] ext_val,
	input  wire logic [7:0] ext_drv,
	output var  logic [7:0] pin_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic flip_q = 1'b0;
	always_ff @(posedge clock) begin
		flip_q <= ~flip_q;
	end
	// a floating pad must not settle to a value the simulator picks
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (pin_oe[i]) pin_in[i] = pin_out[i];
			else if (ext_drv[i]) pin_in[i] = ext_val[i];
			else if (pin_pullup[i]) pin_in[i] = 1'b1;
			else pin_in[i] = flip_q ^ i[0];
		end
	end
endmodule : pa_pin_model
`default_nettype wire

// ===== pa_sync3.sv
// three-stage pin synchroniser, a change counts once stages two and three agree
`default_nettype none
module pa_sync3 (
	input  wire logic clock,
	input  wire logic rst,
	input  wire logic pin_in,
	output var  logic level_out
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic lvl;
	} st_s;
	st_s st_q;
	st_s st_d;

	always_comb begin
		st_d = st_q;
		st_d.s1 = pin_in;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
		if (st_q.s2 == st_q.s3) begin
			st_d.lvl = st_q.s3;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign level_out = st_q.lvl;
endmodule : pa_sync3
`default_nettype wire

// ===== tb_top.sv
// self-checking bench for the port a block
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clock = 1'b0, rst = 1'b1, por = 1'b1, ftf = 1'b0;
	logic       cyc = 1'b0, stb = 1'b0, we = 1'b0, sel = 1'b0;
	logic [3:0] adr = 4'h0;
	logic [7:0] wdat = 8'h00, ext = 8'h00, edrv = 8'hff, rd, rdat, lat, rnd;
	logic [7:0] pin_in, pin_out, pin_oe, pin_pu;
	logic       ack, irq, prio, wake, usb;
	int         miscompares = 0;
	int         check_count = 0;
	always #10 clock = ~clock;
	pa_gpio u_dut (.clock(clock), .rst(rst), .por(por), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat),
		.wb_ack_o(ack), .file_to_file_move(ftf), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe(pin_oe), .pin_pullup(pin_pu), .change_irq(irq),
		.change_irq_priority(prio), .change_wake(wake), .usb_module_enable(usb));
	pa_pin_model u_pins (.clock(clock), .pin_out(pin_out), .pin_oe(pin_oe),
		.pin_pullup(pin_pu), .ext_val(ext), .ext_drv(edrv), .pin_in(pin_in));
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr
	function automatic logic [7:0] exp_pin(input logic [7:0] l, d, e, ioc, input logic u);
		logic [7:0] v;
		v = (l & ~d & 8'h30) | (e & d & 8'h30) | (e & 8'h08);
		if (ioc[1:0] == 2'b11 && !u) v = v | (e & 8'h03);
		return v;
	endfunction : exp_pin
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
		int n;
		@(posedge clock);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (ack !== 1'b1) miscompares++;
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : bus
	task automatic rdc(input string name, input logic [3:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		check(name, rd, e);
	endtask : rdc
	task automatic idle(input int n);
		repeat (n) @(posedge clock);
	endtask : idle
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : end_sim
	// bound well above the few hundred cycles the sequence needs
	initial begin
		#200000;
		miscompares++;
		end_sim();
	end
	initial begin
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		por <= 1'b0;
		bus(1'b1, 4'h9, 8'h06);
		rdc("dir_reset", 4'h1, 8'h30);
		rdc("analog_select_reset", 4'h5, 8'hf8);
		rdc("ioc_reset", 4'h4, 8'h00);
		rdc("unmapped", 4'hf, 8'h00);
		check("pullup_reset", pin_pu, 8'h00);
		bus(1'b1, 4'h5, 8'h00);
		bus(1'b1, 4'h1, 8'h00);
		rnd = 8'h32;
		for (int i = 0; i < 6; i++) begin
			rnd = lfsr(rnd);
			lat = rnd;
			ext <= rnd;
			bus(1'b1, i[0] ? 4'h0 : 4'h2, rnd);
			rdc("latch", 4'h2, lat & 8'h30);
			idle(8);
			check("oe", pin_oe, 8'h30);
			check("out", pin_out & 8'h30, lat & 8'h30);
			rdc("pin", 4'h0, exp_pin(lat, 8'h00, rnd, 8'h00, 1'b0));
		end
		bus(1'b1, 4'h9, 8'h16);
		rdc("bit3_master_clear_input", 4'h0, exp_pin(lat, 8'h00, rnd, 8'h00, 1'b0) & 8'hf7);
		bus(1'b1, 4'h9, 8'h06);
		bus(1'b1, 4'h1, 8'h30);
		bus(1'b1, 4'h3, 8'h38);
		bus(1'b1, 4'h8, 8'h00);
		idle(2);
		check("pullup", pin_pu, 8'h38);
		edrv <= 8'hf7;
		idle(8);
		rdc("pin_pulled", 4'h0, exp_pin(lat, 8'h30, rnd | 8'h08, 8'h00, 1'b0));
		edrv <= 8'hff;
		bus(1'b1, 4'h1, 8'h00);
		idle(2);
		check("pullup_out", pin_pu, 8'h08);
		bus(1'b1, 4'h8, 8'h81);
		idle(2);
		check("pullup_off", pin_pu, 8'h00);
		check("prio", {7'h00, prio}, 8'h01);
		bus(1'b1, 4'h1, 8'h30);
		ext <= 8'h00;
		bus(1'b1, 4'h4, 8'h30);
		idle(8);
		bus(1'b0, 4'h0, 8'h00);
		bus(1'b1, 4'h7, 8'h08);
		idle(8);
		check("irq_quiet", {7'h00, irq}, 8'h00);
		ext <= 8'h20;
		idle(8);
		check("irq_change", {7'h00, irq}, 8'h01);
		check("wake", {7'h00, wake}, 8'h01);
		bus(1'b1, 4'h7, 8'h08);
		idle(3);
		check("irq_sticky", {7'h00, irq}, 8'h01);
		ftf <= 1'b1;
		bus(1'b0, 4'h0, 8'h00);
		ftf <= 1'b0;
		bus(1'b1, 4'h7, 8'h08);
		idle(3);
		check("irq_move", {7'h00, irq}, 8'h01);
		bus(1'b0, 4'h0, 8'h00);
		bus(1'b1, 4'h7, 8'h08);
		idle(3);
		check("irq_cleared", {7'h00, irq}, 8'h00);
		ext <= 8'h00;
		bus(1'b1, 4'h7, 8'h00);
		idle(8);
		check("irq_gated", {7'h00, irq}, 8'h00);
		bus(1'b1, 4'h7, 8'h08);
		idle(3);
		check("irq_enabled", {7'h00, irq}, 8'h01);
		@(posedge clock);
		rst <= 1'b1;
		@(posedge clock);
		rst <= 1'b0;
		bus(1'b1, 4'h9, 8'h06);
		bus(1'b1, 4'h5, 8'h00);
		bus(1'b1, 4'h4, 8'h30);
		bus(1'b1, 4'h7, 8'h08);
		idle(3);
		check("irq_after_rst", {7'h00, irq}, 8'h01);
		bus(1'b0, 4'h0, 8'h00);
		bus(1'b1, 4'h7, 8'h08);
		bus(1'b1, 4'h1, 8'h00);
		bus(1'b1, 4'h2, 8'h20);
		idle(8);
		check("irq_output", {7'h00, irq}, 8'h00);
		bus(1'b1, 4'h1, 8'h30);
		ext <= 8'h03;
		bus(1'b1, 4'h4, 8'h03);
		idle(8);
		rdc("pin_usb_off", 4'h0, exp_pin(8'h00, 8'h30, 8'h03, 8'h03, 1'b0));
		bus(1'b1, 4'h7, 8'h08);
		ext <= 8'h02;
		idle(8);
		check("irq_bit0", {7'h00, irq}, 8'h01);
		bus(1'b1, 4'h6, 8'h08);
		bus(1'b0, 4'h0, 8'h00);
		bus(1'b1, 4'h7, 8'h08);
		ext <= 8'h01;
		idle(8);
		check("irq_usb", {7'h00, irq}, 8'h00);
		check("usb_en", {7'h00, usb}, 8'h01);
		rdc("pin_usb_on", 4'h0, exp_pin(8'h00, 8'h30, 8'h01, 8'h03, 1'b1));
		bus(1'b1, 4'h1, 8'h00);
		bus(1'b1, 4'h9, 8'h03);
		idle(2);
		check("cycle_clock_output_oe", pin_oe & 8'h10, 8'h10);
		bus(1'b1, 4'h9, 8'h01);
		rdc("dir_crystal", 4'h1, 8'h30);
		end_sim();
	end
endmodule : tb_top
`default_nettype wire
